// >>> branch_load_pkg.sv
// constants and types shared by the branch and load execution unit
`default_nettype none
package branch_load_pkg;

  // apb register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ARG = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_PTR_X = 8'h10;
  localparam logic [7:0] ADDR_PTR_Y = 8'h14;
  localparam logic [7:0] ADDR_PTR_Z = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_GPR = 8'h20;

  // operation codes in the command word
  localparam logic [4:0] OP_BRANCH_CARRY_CLEAR = 5'h00;
  localparam logic [4:0] OP_BRANCH_SAME_OR_HIGHER = 5'h01;
  localparam logic [4:0] OP_BRANCH_LOWER = 5'h02;
  localparam logic [4:0] OP_BRANCH_NEGATIVE = 5'h03;
  localparam logic [4:0] OP_BRANCH_POSITIVE = 5'h04;
  localparam logic [4:0] OP_BRANCH_SIGNED_GE = 5'h05;
  localparam logic [4:0] OP_BRANCH_SIGNED_LESS = 5'h06;
  localparam logic [4:0] OP_BRANCH_HALFCARRY_SET = 5'h07;
  localparam logic [4:0] OP_BRANCH_HALFCARRY_CLEAR = 5'h08;
  localparam logic [4:0] OP_BRANCH_TRANSFER_SET = 5'h09;
  localparam logic [4:0] OP_BRANCH_TRANSFER_CLEAR = 5'h0A;
  localparam logic [4:0] OP_BRANCH_IRQ_ENABLED = 5'h0B;
  localparam logic [4:0] OP_BRANCH_IRQ_DISABLED = 5'h0C;
  localparam logic [4:0] OP_POINTER_LOAD = 5'h0D;
  localparam logic [4:0] OP_POINTER_LOAD_POST_INC = 5'h0E;
  localparam logic [4:0] OP_POINTER_LOAD_PRE_DEC = 5'h0F;
  localparam logic [4:0] OP_DISPLACED_POINTER_LOAD = 5'h10;
  localparam logic [4:0] OP_DIRECT_MEMORY_LOAD = 5'h11;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PTR_LSB = 5;
  localparam int CMD_DST_LSB = 7;

  // pointer selection
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // status register bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_ERR = 2;

  // values after reset
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] ARG_RESET = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} state_type;

  function automatic logic is_branch(input logic [4:0] op);
    is_branch = (op <= OP_BRANCH_IRQ_DISABLED);
  endfunction : is_branch

endpackage : branch_load_pkg
`default_nettype wire

// >>> branch_cond.sv
// flag test for the conditional relative branches
`timescale 1ns/100ps
`default_nettype none
module branch_cond
  import branch_load_pkg::*;
(
  input wire logic [4:0] op,
  input wire logic [7:0] flags,
  output logic taken
);

  always_comb
  begin
    unique case (op)
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_OR_HIGHER: taken = ~flags[FLAG_C];
      OP_BRANCH_LOWER: taken = flags[FLAG_C];
      OP_BRANCH_NEGATIVE: taken = flags[FLAG_N];
      OP_BRANCH_POSITIVE: taken = ~flags[FLAG_N];
      OP_BRANCH_SIGNED_GE: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: taken = flags[FLAG_N] ^ flags[FLAG_V];
      OP_BRANCH_HALFCARRY_SET: taken = flags[FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: taken = ~flags[FLAG_H];
      OP_BRANCH_TRANSFER_SET: taken = flags[FLAG_T];
      OP_BRANCH_TRANSFER_CLEAR: taken = ~flags[FLAG_T];
      OP_BRANCH_IRQ_ENABLED: taken = flags[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: taken = ~flags[FLAG_I];
      // loads and illegal codes never branch
      default: taken = 1'b0;
    endcase
  end

endmodule : branch_cond
`default_nettype wire

// >>> branch_load_exec.sv
// branch and data load execution unit with apb register access
// Overview of operation
// - carry clear branches jump when carry is 0
// - lower branch jumps when carry is 1
// - negative branch on N=1, positive on N=0
// - signed branches test N xor V
// - half carry branches test H flag
// - transfer branches test T flag
// - interrupt branches test I, 1/2 cycles
// - branches never change status flags
// - post increment load reads then bumps pointer
// - pre decrement load decrements then reads
// - displaced load reads pointer plus q
// - direct load reads address k, 2 cycles
`timescale 1ns/100ps
`default_nettype none
module branch_load_exec
  import branch_load_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] mem_addr,
  output logic mem_re,
  input wire logic [7:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CMD) || (a == ADDR_ARG) || (a == ADDR_FLAGS) ||
              (a == ADDR_PC) || (a == ADDR_PTR_X) || (a == ADDR_PTR_Y) ||
              (a == ADDR_PTR_Z) || (a == ADDR_STATUS) || (a == ADDR_GPR);
  endfunction : addr_ok
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      merge_bytes[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge_bytes
  ////////////////////////////////////////////////////////////////////////////
  state_type state_q, state_d;
  logic [4:0] op_q, op_d;
  logic [1:0] ptr_sel_q, ptr_sel_d;
  logic [4:0] dst_q, dst_d;
  logic [15:0] arg_q, arg_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] ptr_q [3];
  logic [15:0] ptr_d [3];
  logic [7:0] gpr_q [32];
  logic [7:0] gpr_d [32];
  logic [4:0] gpr_sel_q, gpr_sel_d;
  logic taken_q, taken_d;
  logic err_q, err_d;
  logic [15:0] mem_addr_q, mem_addr_d;
  logic mem_re_q, mem_re_d;
  logic [31:0] prdata_q, prdata_d;
  logic apb_setup, apb_write, br_taken, new_legal;
  logic [15:0] k_ext, br_target, cur_ptr, cmd_ptr;
  logic [31:0] wmerged;
  logic [4:0] new_op;
  logic [1:0] new_ptr;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata = prdata_q;
  assign mem_addr = mem_addr_q;
  assign mem_re = mem_re_q;
  assign cur_ptr = ptr_q[ptr_sel_q];
  assign k_ext = {{9{arg_q[6]}}, arg_q[6:0]};
  assign br_target = pc_q + k_ext + 16'h0001;
  assign new_op = pwdata[CMD_OP_LSB +: 5];
  assign new_ptr = pwdata[CMD_PTR_LSB +: 2];
  assign cmd_ptr = ptr_q[new_ptr];
  // displaced form only knows the y and z pointers
  assign new_legal = (new_op <= OP_DIRECT_MEMORY_LOAD) &&
    (new_ptr != 2'h3) &&
    !(new_op == OP_DISPLACED_POINTER_LOAD && new_ptr == PTR_X);
  branch_cond u_branch_cond (
    .op(op_q),
    .flags(flags_q),
    .taken(br_taken)
  );
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    ptr_sel_d = ptr_sel_q;
    dst_d = dst_q;
    arg_d = arg_q;
    pc_d = pc_q;
    flags_d = flags_q;
    ptr_d = ptr_q;
    gpr_d = gpr_q;
    gpr_sel_d = gpr_sel_q;
    taken_d = taken_q;
    err_d = err_q;
    mem_addr_d = mem_addr_q;
    mem_re_d = 1'b0;
    prdata_d = prdata_q;
    wmerged = 32'h0000_0000;
    // read data is captured in the setup cycle
    if (apb_setup && !pwrite)
    begin
      unique case (paddr)
        ADDR_ARG: prdata_d = {16'h0000, arg_q};
        ADDR_FLAGS: prdata_d = {24'h00_0000, flags_q};
        ADDR_PC: prdata_d = {16'h0000, pc_q};
        ADDR_PTR_X: prdata_d = {16'h0000, ptr_q[PTR_X]};
        ADDR_PTR_Y: prdata_d = {16'h0000, ptr_q[PTR_Y]};
        ADDR_PTR_Z: prdata_d = {16'h0000, ptr_q[PTR_Z]};
        ADDR_STATUS: prdata_d = {29'h0000_0000, err_q, taken_q,
                                 state_q != ST_IDLE};
        ADDR_GPR: prdata_d = {19'h0_0000, gpr_sel_q, gpr_q[gpr_sel_q]};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (apb_write)
    begin
      unique case (paddr)
        ADDR_CMD:
        begin
          // a command while busy is dropped
          if (state_q == ST_IDLE && pstrb[0])
          begin
            err_d = !new_legal;
            if (new_legal)
            begin
              op_d = new_op;
              ptr_sel_d = new_ptr;
              dst_d = pwdata[CMD_DST_LSB +: 5];
              state_d = ST_EXEC;
              unique case (new_op)
                OP_POINTER_LOAD_PRE_DEC:
                  mem_addr_d = cmd_ptr - 16'h0001;
                OP_DISPLACED_POINTER_LOAD:
                  mem_addr_d = cmd_ptr + {10'h000, arg_q[5:0]};
                OP_DIRECT_MEMORY_LOAD: mem_addr_d = arg_q;
                default: mem_addr_d = cmd_ptr;
              endcase
              mem_re_d = !is_branch(new_op);
            end
          end
        end
        ADDR_ARG:
        begin
          wmerged = merge_bytes({16'h0000, arg_q}, pwdata, pstrb);
          arg_d = wmerged[15:0];
        end
        ADDR_FLAGS:
        begin
          wmerged = merge_bytes({24'h00_0000, flags_q}, pwdata, pstrb);
          flags_d = wmerged[7:0];
        end
        ADDR_PC:
        begin
          wmerged = merge_bytes({16'h0000, pc_q}, pwdata, pstrb);
          pc_d = wmerged[15:0];
        end
        ADDR_PTR_X, ADDR_PTR_Y, ADDR_PTR_Z:
        begin
          wmerged = merge_bytes({16'h0000, ptr_q[paddr[3:2]]}, pwdata,
                                pstrb);
          ptr_d[paddr[3:2]] = wmerged[15:0];
        end
        ADDR_GPR:
        begin
          if (pstrb[1])
          begin
            gpr_sel_d = pwdata[12:8];
          end
        end
        default: ;
      endcase
    end
    // execution overrides a register write in the same cycle
    unique case (state_q)
      ST_IDLE: ;
      ST_EXEC:
      begin
        pc_d = (is_branch(op_q) && br_taken) ? br_target : pc_q + 16'h0001;
        state_d = (is_branch(op_q) && !br_taken) ? ST_IDLE : ST_SECOND;
        taken_d = is_branch(op_q) ? br_taken : taken_q;
      end
      ST_SECOND:
      begin
        if (!is_branch(op_q))
        begin
          // data arrives one cycle after the read
          gpr_d[dst_q] = mem_rdata;
          if (op_q == OP_POINTER_LOAD_POST_INC)
          begin
            ptr_d[ptr_sel_q] = cur_ptr + 16'h0001;
          end
          else if (op_q == OP_POINTER_LOAD_PRE_DEC)
          begin
            ptr_d[ptr_sel_q] = mem_addr_q;
          end
        end
        state_d = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_POINTER_LOAD;
      ptr_sel_q <= PTR_X;
      dst_q <= 5'h00;
      arg_q <= ARG_RESET;
      pc_q <= PC_RESET;
      flags_q <= FLAGS_RESET;
      ptr_q <= '{default: PTR_RESET};
      gpr_q <= '{default: 8'h00};
      gpr_sel_q <= 5'h00;
      taken_q <= 1'b0;
      err_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_re_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      ptr_sel_q <= ptr_sel_d;
      dst_q <= dst_d;
      arg_q <= arg_d;
      pc_q <= pc_d;
      flags_q <= flags_d;
      ptr_q <= ptr_d;
      gpr_q <= gpr_d;
      gpr_sel_q <= gpr_sel_d;
      taken_q <= taken_d;
      err_q <= err_d;
      mem_addr_q <= mem_addr_d;
      mem_re_q <= mem_re_d;
      prdata_q <= prdata_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic exec, flags_wr;
  assign exec = (state_q == ST_EXEC);
  assign flags_wr = apb_write && (paddr == ADDR_FLAGS);
  sequence s_jump;
    ##1 (pc_q == $past(br_target)) ##1 (state_q == ST_IDLE);
  endsequence
  sequence s_skip;
    ##1 (pc_q == $past(pc_q) + 16'h0001) && (state_q == ST_IDLE);
  endsequence
  sequence s_load_done;
    ##1 (state_q == ST_SECOND) ##1 (state_q == ST_IDLE) &&
      (gpr_q[dst_q] == $past(mem_rdata));
  endsequence
  a_carry_clear_jump: assert property (
    exec && (op_q == OP_BRANCH_CARRY_CLEAR ||
             op_q == OP_BRANCH_SAME_OR_HIGHER) && !flags_q[FLAG_C]
    |-> s_jump)
    else $error("carry clear branch did not jump");
  a_lower_branch: assert property (
    exec && op_q == OP_BRANCH_LOWER
    |-> if (flags_q[FLAG_C]) s_jump else s_skip)
    else $error("lower branch wrong outcome");
  a_negative_branch: assert property (
    exec && ((op_q == OP_BRANCH_NEGATIVE && flags_q[FLAG_N]) ||
             (op_q == OP_BRANCH_POSITIVE && !flags_q[FLAG_N]))
    |-> s_jump)
    else $error("negative flag branch did not jump");
  a_signed_branch: assert property (
    exec && op_q == OP_BRANCH_SIGNED_GE
    |-> if (flags_q[FLAG_N] ^ flags_q[FLAG_V]) s_skip else s_jump)
    else $error("signed branch wrong outcome");
  a_halfcarry_branch: assert property (
    exec && op_q == OP_BRANCH_HALFCARRY_CLEAR
    |-> if (flags_q[FLAG_H]) s_skip else s_jump)
    else $error("half carry branch wrong outcome");
  a_transfer_branch: assert property (
    exec && op_q == OP_BRANCH_TRANSFER_SET
    |-> if (flags_q[FLAG_T]) s_jump else s_skip)
    else $error("transfer branch wrong outcome");
  a_irq_branch: assert property (
    exec && op_q == OP_BRANCH_IRQ_DISABLED
    |-> if (flags_q[FLAG_I]) s_skip else s_jump)
    else $error("interrupt branch wrong outcome");
  a_flags_kept: assert property (
    exec && is_branch(op_q) && !flags_wr |=> $stable(flags_q))
    else $error("branch changed status flags");
  a_post_inc_load: assert property (
    exec && op_q == OP_POINTER_LOAD_POST_INC
    |-> mem_re && mem_addr == cur_ptr ##0 s_load_done
        ##0 (cur_ptr == $past(cur_ptr, 2) + 16'h0001))
    else $error("post increment load wrong");
  a_pre_dec_load: assert property (
    exec && op_q == OP_POINTER_LOAD_PRE_DEC
    |-> mem_re && mem_addr == cur_ptr - 16'h0001 ##0 s_load_done
        ##0 (cur_ptr == $past(mem_addr, 2)))
    else $error("pre decrement load wrong");
  a_displaced_load: assert property (
    exec && op_q == OP_DISPLACED_POINTER_LOAD
    |-> mem_addr == cur_ptr + {10'h000, arg_q[5:0]} ##0 s_load_done
        ##0 $stable(cur_ptr))
    else $error("displaced load wrong");
  a_direct_load: assert property (
    exec && op_q == OP_DIRECT_MEMORY_LOAD && !flags_wr
    |-> mem_re && mem_addr == arg_q ##0 s_load_done
        ##0 (flags_q == $past(flags_q, 2)))
    else $error("direct load wrong");
  a_backward_jump: assert property (
    exec && is_branch(op_q) && br_taken && arg_q[6:0] == 7'h7F
    |=> pc_q == $past(pc_q))
    else $error("offset minus one did not loop");

endmodule : branch_load_exec
`default_nettype wire

// >>> data_mem_model.sv
// data memory partner answering one cycle after each read strobe
`timescale 1ns/100ps
`default_nettype none
module data_mem_model
(
  input wire logic pclk,
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // idle: inverted data so a late sample never matches
    rdata_d = ~rdata_q;
    if (mem_re === 1'b1)
    begin
      rdata_d = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
    end
  end
  always_ff @(posedge pclk)
  begin
    rdata_q <= rdata_d;
  end
  assign mem_rdata = rdata_q;
endmodule : data_mem_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the branch and load execution unit
`timescale 1ns/100ps
`default_nettype none
`define check_eq(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module tb_top
  import branch_load_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_re;
  logic err_seen;
  logic [7:0] paddr, mem_rdata;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] mem_addr, seen_addr;
  int num_errors = 0;
  int checks = 0;
  int re_count = 0;
  //////////////////////////////////////////////////////////////////////////
  branch_load_exec uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_re(mem_re), .mem_rdata(mem_rdata));
  data_mem_model mem (.pclk(pclk), .mem_re(mem_re), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (mem_re === 1'b1)
    begin
      seen_addr <= mem_addr;
      re_count <= re_count + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // b2b keeps psel up so the next setup follows at once
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic b2b, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    if (!b2b)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 1'b0, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0000_0000, 1'b0, r);
  endtask : rd
  task automatic wait_idle;
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      rd(ADDR_STATUS, r);
      n++;
    end
    while (r[STAT_BUSY] !== 1'b0 && n < 20);
    `check_eq(r[STAT_BUSY], 1'b0)
  endtask : wait_idle
  function automatic logic want(input logic [4:0] op, input logic [7:0] f);
    case (op)
      5'h00, 5'h01: want = ~f[FLAG_C];
      5'h02: want = f[FLAG_C];
      5'h03: want = f[FLAG_N];
      5'h04: want = ~f[FLAG_N];
      5'h05: want = ~(f[FLAG_N] ^ f[FLAG_V]);
      5'h06: want = f[FLAG_N] ^ f[FLAG_V];
      5'h07: want = f[FLAG_H];
      5'h08: want = ~f[FLAG_H];
      5'h09: want = f[FLAG_T];
      5'h0A: want = ~f[FLAG_T];
      5'h0B: want = f[FLAG_I];
      default: want = ~f[FLAG_I];
    endcase
  endfunction : want
  //////////////////////////////////////////////////////////////////////////
  task automatic check_reset;
    logic [31:0] r;
    for (int a = 0; a <= 32; a += 4)
    begin
      rd(8'(a), r);
      `check_eq(r, 32'h0000_0000)
      `check_eq(err_seen, 1'b0)
    end
  endtask : check_reset
  // every code, both outcomes, k at both signed extremes
  task automatic run_branches;
    logic [7:0] fl [3] = '{8'h00, 8'hFF, 8'h04};
    logic [6:0] kt [3] = '{7'h3F, 7'h40, 7'h7F};
    logic [31:0] r;
    logic [15:0] pc;
    logic t;
    for (int op = 0; op <= 12; op++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        wr(ADDR_PC, 32'h0000_0100);
        wr(ADDR_FLAGS, {24'h0, fl[i]});
        wr(ADDR_ARG, {25'h0, kt[i]});
        wr(ADDR_CMD, 32'(op));
        wait_idle;
        t = want(5'(op), fl[i]);
        pc = t ? 16'h0101 + {{9{kt[i][6]}}, kt[i]} : 16'h0101;
        rd(ADDR_PC, r);
        `check_eq(r, {16'h0, pc})
        rd(ADDR_FLAGS, r);
        `check_eq(r, {24'h0, fl[i]})
        rd(ADDR_STATUS, r);
        `check_eq(r, {29'h0, 1'b0, t, 1'b0})
      end
    end
  endtask : run_branches
  task automatic do_load(input logic [4:0] op, input logic [1:0] p,
    input logic [4:0] dst, input logic [15:0] pv, input logic [15:0] arg,
    input logic [15:0] ea, input logic [15:0] ep);
    logic [7:0] pa;
    logic [31:0] r;
    int n0;
    pa = ADDR_PTR_X + {4'h0, p, 2'b00};
    wr(ADDR_PC, 32'h0000_0040);
    wr(ADDR_FLAGS, 32'h0000_00A5);
    wr(pa, {16'h0, pv});
    wr(ADDR_ARG, {16'h0, arg});
    n0 = re_count;
    wr(ADDR_CMD, 32'(op) | 32'(p) << CMD_PTR_LSB | 32'(dst) << CMD_DST_LSB);
    wait_idle;
    `check_eq(seen_addr, ea)
    `check_eq(re_count - n0, 1)
    wr(ADDR_GPR, {19'h0, dst, 8'h00});
    rd(ADDR_GPR, r);
    `check_eq(r, {19'h0, dst, ea[7:0] ^ ea[15:8] ^ 8'hA5})
    rd(pa, r);
    `check_eq(r, {16'h0, ep})
    rd(ADDR_PC, r);
    `check_eq(r, 32'h0000_0041)
    rd(ADDR_FLAGS, r);
    `check_eq(r, 32'h0000_00A5)
  endtask : do_load
  task automatic run_loads;
    do_load(5'h0D, PTR_X, 5'd0, 16'h1234, 16'h0000, 16'h1234, 16'h1234);
    do_load(5'h0E, PTR_Y, 5'd31, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000);
    do_load(5'h0F, PTR_Z, 5'd16, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF);
    do_load(5'h10, PTR_Z, 5'd5, 16'h0FF0, 16'h003F, 16'h102F, 16'h0FF0);
    do_load(5'h10, PTR_Y, 5'd6, 16'h2000, 16'hFFC3, 16'h2003, 16'h2000);
    do_load(5'h11, PTR_X, 5'd7, 16'h5555, 16'hABCD, 16'hABCD, 16'h5555);
  endtask : run_loads
  // refusals: unmapped, illegal codes, command while busy
  task automatic check_refusals;
    logic [31:0] r;
    int n0;
    rd(8'h40, r);
    `check_eq(err_seen, 1'b1)
    `check_eq(r, 32'h0000_0000)
    wr(ADDR_PC, 32'h0000_0077);
    wr(ADDR_CMD, 32'h0000_001F);
    wait_idle;
    rd(ADDR_STATUS, r);
    `check_eq(r[STAT_ERR], 1'b1)
    wr(ADDR_CMD, 32'h0000_0010);
    wait_idle;
    rd(ADDR_PC, r);
    `check_eq(r, 32'h0000_0077)
    wr(ADDR_PC, 32'h0000_0200);
    wr(ADDR_FLAGS, 32'h0000_0000);
    wr(ADDR_ARG, 32'h0000_0005);
    n0 = re_count;
    apb(1'b1, ADDR_CMD, 32'h0000_008D, 1'b1, r);
    wr(ADDR_CMD, 32'h0000_0000);
    wait_idle;
    rd(ADDR_PC, r);
    `check_eq(r, 32'h0000_0201)
    `check_eq(re_count - n0, 1)
  endtask : check_refusals
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_reset;
    run_branches;
    run_loads;
    check_refusals;
    close_out;
  end
  // about 1300 cycles expected; cut off well beyond that
  initial
  begin
    #200000;
    num_errors++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
